/* File: design/serial_command_port.sv */
// Serial command front end: switch setup, command framing and registers.
//
// Design decisions made here: the register offsets and strobed register access.

module serial_command_port
   import scp_pkg::*;
#(
   parameter int CMD_DEPTH = 16,
   parameter int N_SP = 5,
   parameter int N_CH = 5
)
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic rxd,
   input wire logic [6:0] serial_setup_switch_bank,
   input wire logic [7:0] node_address_switch_bank,
   input wire logic [1:0] units_sel,
   input wire logic [N_CH-1:0][3:0] module_type,
   input wire logic [N_CH-1:0][3:0] head_range,
   input wire logic [N_CH-1:0][15:0] factory_cal,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   output logic multidrop_mode,
   output logic rs485_sel,
   output logic rs232_sel,
   output logic reply_allowed
);
   if (CMD_DEPTH < 1 || CMD_DEPTH > 16)
      $error("serial_command_port supports a command depth of 1 to 16");

   localparam int LEN_W = $clog2(CMD_DEPTH + 1);
   localparam logic [LEN_W-1:0] LEN_FULL = LEN_W'(CMD_DEPTH);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [2:0] decode_rate(logic [3:0] sw);
      case (sw)
         4'h1: return {RATE_2400, 1'b1};
         4'he: return {RATE_2400, 1'b0};
         4'h2: return {RATE_4800, 1'b1};
         4'hd: return {RATE_4800, 1'b0};
         4'h4: return {RATE_9600, 1'b1};
         4'hb: return {RATE_9600, 1'b0};
         4'h8: return {RATE_19200, 1'b1};
         4'h7: return {RATE_19200, 1'b0};
         default: return {RATE_9600, 1'b1};
      endcase
   endfunction : decode_rate

   function automatic logic in_window(logic [7:0] a, logic [7:0] base, int n);
      return (a[1:0] == 2'h0) && (a >= base) && ({1'b0, a} < {1'b0, base} + 9'(4 * n));
   endfunction : in_window

   function automatic logic [5:0] word_index(logic [7:0] a, logic [7:0] base);
      logic [7:0] d;
      d = a - base;
      return d[7:2];
   endfunction : word_index

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] rx_s;
      logic rxd_q;
      logic [6:0] sw_s1;
      logic [6:0] sw_s2;
      logic [6:0] sw_s3;
      logic [6:0] sw_q;
      logic [7:0] ad_s1;
      logic [7:0] ad_s2;
      logic [7:0] ad_s3;
      logic [7:0] ad_q;
      logic [10:0] div_cnt;
      logic tick;
      frame_state_t fr;
      logic [LEN_W-1:0] len;
      logic [CMD_DEPTH-1:0][7:0] cmd;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      logic [31:0] rdata;
   } port_t;
   port_t s_q, s_d;

   rx_char_if rx_link ();
   store_if #(.N_SP(N_SP), .N_CH(N_CH)) st_link ();

   rate_t rate;
   logic par_en;
   logic md;
   frame_state_t restart;
   logic [5:0] bus_idx;

   assign {rate, par_en} = decode_rate(s_q.sw_q[3:0]);
   assign md = s_q.sw_q[SW_PROTO];
   assign restart = md ? FR_ATTN : FR_COLLECT;
   assign bus_idx = word_index(reg_addr, reg_addr >= OFS_CAL_BASE ? OFS_CAL_BASE :
                               reg_addr >= OFS_SP_BASE ? OFS_SP_BASE : OFS_CMD_BASE);

   // ----------------------------------------------------------------
   // Store write decode
   // ----------------------------------------------------------------
   assign st_link.wdata = reg_wdata[16:0];
   assign st_link.idx = bus_idx[2:0];
   assign st_link.lo_we = reg_wr && reg_addr == OFS_RANGE_LO;
   assign st_link.hi_we = reg_wr && reg_addr == OFS_RANGE_HI;
   assign st_link.sp_we = reg_wr && in_window(reg_addr, OFS_SP_BASE, N_SP);
   assign st_link.cal_we = reg_wr && in_window(reg_addr, OFS_CAL_BASE, N_CH);

   assign rx_link.tick = s_q.tick;
   assign rx_link.par_en = par_en;
   assign rx_link.rxd = s_q.rxd_q;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.tick = 1'b0;
      s_d.rdata = 32'h0000_0000;

      // Pins pass three flops; a change is taken once the last two agree.
      s_d.rx_s = {s_q.rx_s[1:0], rxd};
      if (s_q.rx_s[1] == s_q.rx_s[2])
         s_d.rxd_q = s_q.rx_s[2];
      s_d.sw_s1 = serial_setup_switch_bank;
      s_d.sw_s2 = s_q.sw_s1;
      s_d.sw_s3 = s_q.sw_s2;
      if (s_q.sw_s2 == s_q.sw_s3)
         s_d.sw_q = s_q.sw_s3;
      s_d.ad_s1 = node_address_switch_bank;
      s_d.ad_s2 = s_q.ad_s1;
      s_d.ad_s3 = s_q.ad_s2;
      if (s_q.ad_s2 == s_q.ad_s3)
         s_d.ad_q = s_q.ad_s3;

      // A new rate takes effect at the next reload, so the count in progress still runs out at the old rate.
      if (s_q.div_cnt == 11'h000)
      begin
         s_d.tick = 1'b1;
         s_d.div_cnt = rate_div(rate) - 11'h001;
      end
      else
         s_d.div_cnt = s_q.div_cnt - 11'h001;

      // ----------------------------------------------------------------
      // Register port
      // ----------------------------------------------------------------
      if (reg_rd)
      begin
         if (reg_addr == OFS_STATUS)
         begin
            s_d.rdata = 32'(s_q.status);
            s_d.status = '0;
         end
         else if (reg_addr == OFS_MASK)
            s_d.rdata = 32'(s_q.mask);
         else if (reg_addr == OFS_CONFIG)
            s_d.rdata = {16'h0000, s_q.ad_q, 3'h0, rs485_sel, md, par_en, rate};
         else if (reg_addr == OFS_CMD_CTRL)
            s_d.rdata = {16'h0000, 8'(s_q.len), 7'h00, s_q.fr == FR_HOLD};
         else if (reg_addr == OFS_RANGE_LO)
            s_d.rdata = 32'(st_link.lo);
         else if (reg_addr == OFS_RANGE_HI)
            s_d.rdata = 32'(st_link.hi);
         else if (in_window(reg_addr, OFS_CMD_BASE, CMD_DEPTH))
            s_d.rdata = 32'(s_q.cmd[bus_idx[3:0]]);
         else if (in_window(reg_addr, OFS_SP_BASE, N_SP))
            s_d.rdata = 32'(st_link.sp[bus_idx[2:0]]);
         else if (in_window(reg_addr, OFS_CAL_BASE, N_CH))
            s_d.rdata = 32'(st_link.cal[bus_idx[2:0]]);
      end
      if (reg_wr)
      begin
         if (reg_addr == OFS_MASK)
            s_d.mask = reg_wdata[ST_W-1:0];
         else if (reg_addr == OFS_CMD_CTRL && reg_wdata[0] && s_q.fr == FR_HOLD)
         begin
            s_d.fr = restart;
            s_d.len = '0;
         end
      end

      // ----------------------------------------------------------------
      // Command framing
      // ----------------------------------------------------------------
      if (md != s_q.sw_q[SW_PROTO] || s_d.sw_q[SW_PROTO] != md)
      begin
         if (s_q.fr != FR_HOLD)
         begin
            s_d.fr = s_d.sw_q[SW_PROTO] ? FR_ATTN : FR_COLLECT;
            s_d.len = '0;
         end
      end
      else if (rx_link.valid)
      begin
         if (s_q.fr == FR_HOLD)
            s_d.status[ST_OVR] = 1'b1;
         else if (rx_link.par_err || rx_link.frm_err)
         begin
            s_d.len = '0;
            s_d.fr = restart;
            s_d.status[ST_PAR] = s_q.status[ST_PAR] | rx_link.par_err;
            s_d.status[ST_FRM] = s_q.status[ST_FRM] | rx_link.frm_err;
            if (rx_link.par_err)
               s_d.status[ST_PAR] = 1'b1;
            if (rx_link.frm_err)
               s_d.status[ST_FRM] = 1'b1;
         end
         else
         begin
            case (s_q.fr)
               FR_ATTN:
                  if (rx_link.data == ATTN_CHAR)
                     s_d.fr = FR_ADDR;
               FR_ADDR:
               begin
                  if (rx_link.data == s_q.ad_q)
                  begin
                     s_d.fr = FR_COLLECT;
                     s_d.len = '0;
                  end
                  else if (rx_link.data != ATTN_CHAR)
                     s_d.fr = FR_ATTN;
               end
               FR_COLLECT:
               begin
                  if (md && rx_link.data == ATTN_CHAR)
                  begin
                     s_d.fr = FR_ADDR;
                     s_d.len = '0;
                  end
                  else if (rx_link.data == CMD_END)
                  begin
                     s_d.fr = FR_HOLD;
                     s_d.status[ST_CMD] = 1'b1;
                  end
                  else if (s_q.len == LEN_FULL)
                  begin
                     s_d.fr = restart;
                     s_d.len = '0;
                     s_d.status[ST_OVR] = 1'b1;
                  end
                  else
                  begin
                     s_d.cmd[s_q.len[3:0]] = rx_link.data;
                     s_d.len = s_q.len + LEN_W'(1);
                  end
               end
               default: s_d.fr = restart;
            endcase
         end
      end

      // Events are applied last, so a set beats a clear by read.
      if (st_link.sp_cleared)
         s_d.status[ST_SPC] = 1'b1;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_q <= '0;
         s_q.rx_s <= 3'h7;
         s_q.rxd_q <= 1'b1;
         s_q.sw_q <= SW_RESET;
         s_q.ad_q <= ADDR_RESET;
         s_q.fr <= FR_COLLECT;
         s_q.mask <= MASK_RESET;
      end
      else
         s_q <= s_d;
   end

   // ----------------------------------------------------------------
   // Submodules and outputs
   // ----------------------------------------------------------------
   char_receiver u_rx (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .link(rx_link.rx)
   );

   setpoint_store #(.N_SP(N_SP), .N_CH(N_CH)) u_store (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .units_sel(units_sel),
      .module_type(module_type),
      .head_range(head_range),
      .factory_cal(factory_cal),
      .bus(st_link.store)
   );

   assign reg_rdata = s_q.rdata;
   assign irq = |(s_q.status & s_q.mask);
   assign multidrop_mode = md;
   // Interface from switches six and seven.
   assign rs485_sel = s_q.sw_q[SW_IF485] & ~s_q.sw_q[SW_IF232];
   assign rs232_sel = ~rs485_sel;
   // Replies only for a held, clean command.
   assign reply_allowed = (s_q.fr == FR_HOLD);

endmodule : serial_command_port

/* File: design/scp_pkg.sv */
// Constants, types and helpers shared by the serial command port files.
package scp_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int OVS = 16;
   localparam int BAUD_2400 = 2400;
   localparam int BAUD_4800 = 4800;
   localparam int BAUD_9600 = 9600;
   localparam int BAUD_19200 = 19200;
   localparam logic [10:0] DIV_2400 = 11'(CLK_HZ / (OVS * BAUD_2400));
   localparam logic [10:0] DIV_4800 = 11'(CLK_HZ / (OVS * BAUD_4800));
   localparam logic [10:0] DIV_9600 = 11'(CLK_HZ / (OVS * BAUD_9600));
   localparam logic [10:0] DIV_19200 = 11'(CLK_HZ / (OVS * BAUD_19200));

   // ----------------------------------------------------------------
   // Characters and switches
   // ----------------------------------------------------------------
   localparam logic [7:0] ATTN_CHAR = 8'h24;
   localparam logic [7:0] CMD_END = 8'h0d;
   localparam int SW_PROTO = 4;
   localparam int SW_IF485 = 5;
   localparam int SW_IF232 = 6;
   localparam logic [6:0] SW_RESET = 7'h00;
   localparam logic [7:0] ADDR_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_CONFIG = 8'h08;
   localparam logic [7:0] OFS_CMD_CTRL = 8'h0c;
   localparam logic [7:0] OFS_RANGE_LO = 8'h10;
   localparam logic [7:0] OFS_RANGE_HI = 8'h14;
   localparam logic [7:0] OFS_CMD_BASE = 8'h40;
   localparam logic [7:0] OFS_SP_BASE = 8'h80;
   localparam logic [7:0] OFS_CAL_BASE = 8'ha0;
   localparam int ST_CMD = 0;
   localparam int ST_PAR = 1;
   localparam int ST_FRM = 2;
   localparam int ST_OVR = 3;
   localparam int ST_SPC = 4;
   localparam int ST_W = 5;
   localparam logic [ST_W-1:0] MASK_RESET = 5'h00;
   localparam int SP_EN_BIT = 16;

   typedef enum logic [1:0] {RATE_2400, RATE_4800, RATE_9600, RATE_19200} rate_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
   typedef enum logic [1:0] {FR_ATTN, FR_ADDR, FR_COLLECT, FR_HOLD} frame_state_t;

   function automatic logic [10:0] rate_div(rate_t r);
      case (r)
         RATE_2400: return DIV_2400;
         RATE_4800: return DIV_4800;
         RATE_19200: return DIV_19200;
         default: return DIV_9600;
      endcase
   endfunction : rate_div

endpackage : scp_pkg

/* File: design/scp_ifs.sv */
// Interfaces between the command port top and its receiver and store.
interface rx_char_if;
   logic tick;
   logic par_en;
   logic rxd;
   logic valid;
   logic [7:0] data;
   logic par_err;
   logic frm_err;
   modport ctl (output tick, output par_en, output rxd,
                input valid, input data, input par_err, input frm_err);
   modport rx (input tick, input par_en, input rxd,
               output valid, output data, output par_err, output frm_err);
endinterface : rx_char_if

interface store_if #(parameter int N_SP = 5, parameter int N_CH = 5);
   logic sp_we;
   logic cal_we;
   logic lo_we;
   logic hi_we;
   logic [2:0] idx;
   logic [16:0] wdata;
   logic [N_SP-1:0][16:0] sp;
   logic [N_CH-1:0][15:0] cal;
   logic [15:0] lo;
   logic [15:0] hi;
   logic sp_cleared;
   modport ctl (output sp_we, output cal_we, output lo_we, output hi_we, output idx,
                output wdata, input sp, input cal, input lo, input hi, input sp_cleared);
   modport store (input sp_we, input cal_we, input lo_we, input hi_we, input idx,
                  input wdata, output sp, output cal, output lo, output hi, output sp_cleared);
endinterface : store_if

/* File: design/char_receiver.sv */
// Oversampling serial character receiver with even parity check.
module char_receiver
   import scp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   rx_char_if.rx link
);
   typedef struct packed {
      rx_state_t st;
      logic [3:0] os;
      logic [2:0] nbit;
      logic [7:0] sh;
      logic par;
      logic valid;
      logic [7:0] data;
      logic perr;
      logic ferr;
   } rx_t;
   rx_t s_q, s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.valid = 1'b0;
      if (link.tick)
      begin
         s_d.os = s_q.os + 4'h1;
         case (s_q.st)
            RX_IDLE:
            begin
               s_d.os = 4'h0;
               if (!link.rxd)
                  s_d.st = RX_START;
            end
            RX_START:
               if (s_q.os == 4'h7)
               begin
                  s_d.os = 4'h0;
                  s_d.nbit = 3'h0;
                  s_d.par = 1'b0;
                  s_d.st = link.rxd ? RX_IDLE : RX_DATA;
               end
            RX_DATA:
               if (s_q.os == 4'hf)
               begin
                  s_d.sh = {link.rxd, s_q.sh[7:1]};
                  s_d.par = s_q.par ^ link.rxd;
                  s_d.nbit = s_q.nbit + 3'h1;
                  if (s_q.nbit == 3'h7)
                     s_d.st = link.par_en ? RX_PAR : RX_STOP;
               end
            RX_PAR:
               if (s_q.os == 4'hf)
               begin
                  s_d.par = s_q.par ^ link.rxd;
                  s_d.st = RX_STOP;
               end
            RX_STOP:
               if (s_q.os == 4'hf)
               begin
                  s_d.valid = 1'b1;
                  s_d.data = s_q.sh;
                  s_d.perr = link.par_en & s_q.par;
                  s_d.ferr = ~link.rxd | s_q.sh[7];
                  s_d.st = RX_IDLE;
               end
            default: s_d.st = RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign link.valid = s_q.valid;
   assign link.data = s_q.data;
   assign link.par_err = s_q.perr;
   assign link.frm_err = s_q.ferr;

endmodule : char_receiver

/* File: design/setpoint_store.sv */
// Set point and calibration store that reacts to configuration changes.
module setpoint_store
   import scp_pkg::*;
#(
   parameter int N_SP = 5,
   parameter int N_CH = 5
)
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [1:0] units_sel,
   input wire logic [N_CH-1:0][3:0] module_type,
   input wire logic [N_CH-1:0][3:0] head_range,
   input wire logic [N_CH-1:0][15:0] factory_cal,
   store_if.store bus
);
   if (N_SP < 1 || N_SP > 8 || N_CH < 1 || N_CH > 8)
      $error("setpoint_store supports 1 to 8 set points and channels");

   typedef struct packed {
      logic primed;
      logic [1:0] units;
      logic [N_CH-1:0][3:0] mtype;
      logic [N_CH-1:0][3:0] head;
      logic [N_SP-1:0][16:0] sp;
      logic [N_CH-1:0][15:0] cal;
      logic [15:0] lo;
      logic [15:0] hi;
      logic cleared;
   } store_t;
   store_t s_q, s_d;

   always_comb
   begin
      logic changed;
      changed = 1'b0;
      s_d = s_q;
      s_d.cleared = 1'b0;
      if (bus.lo_we) s_d.lo = bus.wdata[15:0];
      if (bus.hi_we) s_d.hi = bus.wdata[15:0];
      if (bus.sp_we) s_d.sp[bus.idx] = bus.wdata;
      if (bus.cal_we) s_d.cal[bus.idx] = bus.wdata[15:0];
      s_d.primed = 1'b1;
      s_d.units = units_sel;
      s_d.mtype = module_type;
      s_d.head = head_range;
      if (s_q.primed)
      begin
         changed = (units_sel != s_q.units);
         for (int c = 0; c < N_CH; c++)
            if (module_type[c] != s_q.mtype[c] || head_range[c] != s_q.head[c])
            begin
               changed = 1'b1;
               s_d.cal[c] = factory_cal[c];
            end
         for (int i = 0; i < N_SP; i++)
            if (changed && (s_d.sp[i][15:0] < s_q.lo || s_d.sp[i][15:0] > s_q.hi))
            begin
               s_d.sp[i] = '0;
               s_d.cleared = 1'b1;
            end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign bus.sp = s_q.sp;
   assign bus.cal = s_q.cal;
   assign bus.lo = s_q.lo;
   assign bus.hi = s_q.hi;
   assign bus.sp_cleared = s_q.cleared;

endmodule : setpoint_store

/* File: dv/scp_host_model.sv */
// Host computer model that sends serial characters to the port.
module scp_host_model #(parameter int BIT_NS = 52083)
(
   output logic txd
);
   timeunit 1ns;
   timeprecision 1ns;
   // The line idles at mark between characters.
   initial txd = 1'h1;
   task automatic put(input logic [7:0] c, input logic bad);
      logic [10:0] f;
      f = {1'h1, ^c ^ bad, c, 1'h0};
      for (int i = 0; i < 11; i++)
      begin
         txd = f[i];
         #(BIT_NS);
      end
   endtask : put
endmodule : scp_host_model

/* File: dv/serial_command_port_checker.sv */
// Pin-level assertions for the serial command port.
module serial_command_port_checker
   import scp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [6:0] serial_setup_switch_bank,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic irq,
   input wire logic multidrop_mode,
   input wire logic rs485_sel,
   input wire logic rs232_sel,
   input wire logic reply_allowed
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   logic [6:0] sw;
   logic rel;
   logic clr;
   logic cfg_rd;
   assign sw = serial_setup_switch_bank;
   assign rel = reg_wr && reg_addr == OFS_CMD_CTRL && reg_wdata[0];
   assign clr = reg_rd && reg_addr == OFS_STATUS || reg_wr && reg_addr == OFS_MASK;
   assign cfg_rd = reg_rd && reg_addr == OFS_CONFIG;
   // Eight quiet cycles cover the switch synchroniser and its register.
   sequence s_sw;
      $stable(sw)[*8];
   endsequence
   property p_if_sel;
      rs232_sel == !rs485_sel;
   endproperty
   a_if_sel: assert property (p_if_sel) else $error("select clash");
   property p_proto;
      s_sw |-> multidrop_mode == sw[SW_PROTO];
   endproperty
   a_proto: assert property (p_proto) else $error("protocol select");
   property p_if485;
      s_sw |-> rs485_sel == (sw[SW_IF485] && !sw[SW_IF232]);
   endproperty
   a_if485: assert property (p_if485) else $error("interface select");
   property p_md232;
      s_sw ##0 sw[6:4] == 3'h5 |-> multidrop_mode && rs232_sel;
   endproperty
   a_md232: assert property (p_md232) else $error("multidrop on RS-232");
   property p_dflt;
      s_sw ##0 (sw[3:0] == 4'h0 && cfg_rd) |=> reg_rdata[2:0] == 3'h6;
   endproperty
   a_dflt: assert property (p_dflt) else $error("fallback rate");
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_irq_fall;
      $fell(irq) |-> $past(clr);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped");
   property p_hold;
      reply_allowed |=> reply_allowed == !$past(rel);
   endproperty
   a_hold: assert property (p_hold) else $error("held command");
   c_reply: cover property ($rose(reply_allowed));
   c_irq: cover property ($rose(irq));
   c_md232: cover property (multidrop_mode && rs232_sel);
endmodule : serial_command_port_checker
bind serial_command_port serial_command_port_checker u_chk (.sys_clk, .rstn,
   .serial_setup_switch_bank, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .irq, .multidrop_mode, .rs485_sel, .rs232_sel, .reply_allowed);

/* File: dv/serial_command_port_tb.sv */
// Self-checking bench for the serial command port.
module serial_command_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import scp_pkg::*;
   logic sys_clk = 1'h0;
   logic rstn = 1'h0;
   logic rxd;
   logic [6:0] sw = 7'h00;
   logic [1:0] units_sel = 2'h0;
   logic [4:0][3:0] module_type = 20'h0;
   logic [4:0][3:0] head_range = 20'h0;
   logic [4:0][15:0] factory_cal = 80'h0abc;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [31:0] reg_rdata;
   logic irq;
   logic multidrop_mode;
   logic rs485_sel;
   logic rs232_sel;
   logic reply_allowed;
   int err_total = 0;
   int compares = 0;
   always #10 sys_clk = ~sys_clk;
   scp_host_model host (.txd(rxd));
   serial_command_port dut (.sys_clk, .rstn, .rxd, .serial_setup_switch_bank(sw),
      .node_address_switch_bank(8'h30), .units_sel, .module_type, .head_range,
      .factory_cal, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
      .multidrop_mode, .rs485_sel, .rs232_sel, .reply_allowed);
   // ----
   // Tasks
   // ----
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
      @(posedge sys_clk);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      #1;
      chk(reg_rdata, e);
      @(posedge sys_clk);
   endtask : rdc
   // Pins are sampled at the falling edge, well clear of register updates.
   task automatic pins(input logic [4:0] m, input logic [4:0] e);
      @(negedge sys_clk);
      chk(32'({irq, reply_allowed, multidrop_mode, rs485_sel, rs232_sel} & m), 32'(e));
      @(posedge sys_clk);
   endtask : pins
   task automatic cfg(input logic [6:0] s, input logic [4:0] e);
      sw <= s;
      repeat (10) @(posedge sys_clk);
      pins(5'h07, {2'h0, e[3], e[4], !e[4]});
      rdc(OFS_CONFIG, {16'h0, 8'h30, 3'h0, e});
   endtask : cfg
   task automatic t_cfg;
      cfg(7'h00, 5'h06);
      cfg(7'h4f, 5'h06);
      for (int i = 0; i < 4; i++)
      begin
         cfg({3'h4, 4'h1 << i}, {3'h1, 2'(i)});
         cfg({3'h3, ~(4'h1 << i)}, {3'h6, 2'(i)});
      end
      cfg(7'h58, 5'h0f);
      $display("switch test done");
   endtask : t_cfg
   task automatic t_store;
      rdc(OFS_MASK, 32'h0);
      rdc(8'h3c, 32'h0);
      wr(OFS_RANGE_LO, 32'h10);
      wr(OFS_RANGE_HI, 32'h100);
      wr(OFS_SP_BASE, 32'h1_0050);
      wr(OFS_SP_BASE + 8'h04, 32'h1_0200);
      wr(OFS_CAL_BASE, 32'h1234);
      wr(OFS_CAL_BASE + 8'h04, 32'h5555);
      wr(OFS_MASK, 32'h10);
      module_type[0] <= 4'h1;
      repeat (3) @(posedge sys_clk);
      pins(5'h10, 5'h10);
      rdc(OFS_SP_BASE, 32'h1_0050);
      rdc(OFS_SP_BASE + 8'h04, 32'h0);
      rdc(OFS_CAL_BASE, 32'h0abc);
      rdc(OFS_CAL_BASE + 8'h04, 32'h5555);
      wr(OFS_MASK, 32'h0);
      pins(5'h10, 5'h00);
      wr(OFS_MASK, 32'h10);
      pins(5'h10, 5'h10);
      rdc(OFS_STATUS, 32'h10);
      pins(5'h10, 5'h00);
      units_sel <= 2'h1;
      repeat (3) @(posedge sys_clk);
      rdc(OFS_SP_BASE, 32'h1_0050);
      rdc(OFS_STATUS, 32'h10);
      $display("store test done");
   endtask : t_store
   task automatic t_serial;
      sw <= 7'h48;
      repeat (10) @(posedge sys_clk);
      wr(OFS_MASK, 32'h3);
      host.put(8'h41, 1'h1);
      repeat (2500) @(posedge sys_clk);
      pins(5'h18, 5'h10);
      rdc(OFS_STATUS, 32'h2);
      rdc(OFS_CMD_CTRL, 32'h0);
      host.put(8'h42, 1'h0);
      host.put(CMD_END, 1'h0);
      repeat (2500) @(posedge sys_clk);
      pins(5'h08, 5'h08);
      rdc(OFS_CMD_CTRL, 32'h101);
      rdc(OFS_CMD_BASE, 32'h42);
      wr(OFS_CMD_CTRL, 32'h1);
      pins(5'h08, 5'h00);
      $display("serial test done");
   endtask : t_serial
   task automatic test_done;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   // ----
   // Run
   // ----
   initial
   begin
      repeat (5) @(posedge sys_clk);
      rstn <= 1'h1;
      @(posedge sys_clk);
      t_cfg();
      t_store();
      t_serial();
      test_done();
   end
   // Three characters at 19200 take about 1.7 ms, so 4 ms means a hang.
   initial
   begin
      #4_000_000;
      err_total++;
      test_done();
   end
endmodule : serial_command_port_tb
